// ### flc_code_reader.v
`timescale 1ns/1ps
`default_nettype none
`include "flc_consts.vh"
// ==========================================
// Scan tool read port: index into fault memory
module flc_code_reader (
    // Clock and reset
    input  wire        core_clk,
    input  wire        rst_n,
    // Fault memory image
    input  wire [15:0] stored_codes,
    // Scan tool request
    input  wire        read_req,
    input  wire [3:0]  read_index,
    // Answer
    output reg         read_valid_reg,
    output reg         read_stored_reg
);
    always @(posedge core_clk) begin
        if (!rst_n) begin
            read_valid_reg  <= 1'b0;
            read_stored_reg <= 1'b0;
        end else begin
            read_valid_reg <= read_req;
            if (read_req) begin
                read_stored_reg <= stored_codes[read_index];
            end
        end
    end
endmodule
`default_nettype wire

// ### flc_consts.vh
`ifndef FLC_CONSTS_VH
`define FLC_CONSTS_VH
// ==========================================
// Sizes
`define FLC_NFAULT      16
`define FLC_CODE_W      4
`define FLC_NCYL        4
`define FLC_CNT_W       24
// ==========================================
// Timing, in core_clk cycles at 40 MHz
`define FLC_QUAL_CYC    24'd40000
`define FLC_HOLD_CYC    24'd400000
`define FLC_FLASH_CYC   24'd10000000
// ==========================================
// Lamp states
`define FLC_ST_CHECK    3'd0
`define FLC_ST_OFF      3'd1
`define FLC_ST_QUAL     3'd2
`define FLC_ST_ON       3'd3
`define FLC_ST_HOLD     3'd4
`endif

// ### flc_fault_lamp_controller.v
`timescale 1ns/1ps
`default_nettype none
`include "flc_consts.vh"
// ==========================================
// Fault lamp and trouble code memory
module flc_fault_lamp_controller (
    // Clock and reset (reset = ignition on)
    input  wire        core_clk,
    input  wire        rst_n,
    // Engine state and monitor results
    input  wire        engine_running,
    input  wire [15:0] fault_active,
    input  wire [3:0]  misfire_cyl,
    // Scan tool on the diagnostic connector
    input  wire        clear_codes,
    input  wire        read_req,
    input  wire [3:0]  read_index,
    input  wire [23:0] qual_count,
    input  wire [23:0] hold_count,
    output wire        read_valid,
    output wire        read_stored,
    // Outputs to cluster and injection
    output reg         fault_lamp_reg,
    output reg  [15:0] trouble_code_reg,
    output reg  [3:0]  fuel_cutoff_reg,
    output reg         fault_pending_reg
);
    reg [2:0]  state_reg;
    reg [2:0]  state_next;
    reg [23:0] cnt_reg;
    reg [23:0] flash_cnt_reg;
    reg        flash_phase_reg;
    reg        any_prev_reg;
    wire       any_fault;
    wire       misfire;
    wire       changed;
    assign any_fault = |fault_active;
    assign misfire   = |misfire_cyl;
    assign changed   = any_fault != any_prev_reg;
    // Zero terminal count would wrap to 24'hFFFFFF and qualify only after 2^24 - 1 cycles, so fall back to the default
    function [23:0] term;
        input [23:0] cfg;
        input [23:0] dflt;
        begin
            term = (cfg == 24'h000000) ? dflt : cfg;
        end
    endfunction
    // ==========================================
    // Lamp state machine
    always @* begin
        state_next = state_reg;
        case (state_reg)
            `FLC_ST_CHECK: begin
                if (any_fault) begin
                    state_next = `FLC_ST_QUAL;
                end else if (engine_running) begin
                    state_next = `FLC_ST_OFF;
                end
            end
            `FLC_ST_OFF: begin
                if (any_fault) begin
                    state_next = `FLC_ST_QUAL;
                end
            end
            `FLC_ST_QUAL: begin
                if (!any_fault) begin
                    state_next = `FLC_ST_OFF;
                end else if (cnt_reg >= term(qual_count, `FLC_QUAL_CYC) - 24'd1) begin
                    state_next = `FLC_ST_ON;
                end
            end
            `FLC_ST_ON: begin
                if (!any_fault) begin
                    state_next = `FLC_ST_HOLD;
                end
            end
            `FLC_ST_HOLD: begin
                if (any_fault) begin
                    state_next = `FLC_ST_ON;
                end else if (cnt_reg >= term(hold_count, `FLC_HOLD_CYC) - 24'd1) begin
                    state_next = `FLC_ST_OFF;
                end
            end
            default: state_next = `FLC_ST_OFF;
        endcase
        if (clear_codes && !any_fault && state_reg != `FLC_ST_CHECK) begin
            state_next = `FLC_ST_OFF;
        end
    end
    always @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg    <= `FLC_ST_CHECK;
            cnt_reg      <= 24'h000000;
            any_prev_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            any_prev_reg <= any_fault;
            if (changed || state_next != state_reg) begin
                cnt_reg <= 24'h000000;
            end else begin
                cnt_reg <= cnt_reg + 24'd1;
            end
        end
    end
    // ==========================================
    // Fault memory, flash and outputs
    always @(posedge core_clk) begin
        if (!rst_n) begin
            trouble_code_reg  <= 16'h0000;
            fault_lamp_reg    <= 1'b1;
            fuel_cutoff_reg   <= 4'h0;
            fault_pending_reg <= 1'b0;
            flash_cnt_reg     <= 24'h000000;
            flash_phase_reg   <= 1'b0;
        end else begin
            // store code; every monitor bit
            // Set wins over clear so a fault in the clear cycle is kept
            if (clear_codes) begin
                trouble_code_reg <= fault_active;
            end else begin
                trouble_code_reg <= trouble_code_reg | fault_active;
            end
            fault_pending_reg <= any_fault;
            if (!misfire || flash_cnt_reg >= `FLC_FLASH_CYC - 24'd1) begin
                flash_cnt_reg   <= 24'h000000;
                flash_phase_reg <= misfire ? ~flash_phase_reg : 1'b1;
            end else begin
                flash_cnt_reg <= flash_cnt_reg + 24'd1;
            end
            fuel_cutoff_reg <= misfire_cyl;
            if (misfire) begin
                fault_lamp_reg <= flash_phase_reg;
            end else begin
                fault_lamp_reg <= (state_next == `FLC_ST_CHECK) ||
                                  (state_next == `FLC_ST_ON) ||
                                  (state_next == `FLC_ST_HOLD);
            end
        end
    end
    flc_code_reader u_reader (
        .core_clk        (core_clk),
        .rst_n           (rst_n),
        .stored_codes    (trouble_code_reg),
        .read_req        (read_req),
        .read_index      (read_index),
        .read_valid_reg  (read_valid),
        .read_stored_reg (read_stored)
    );
endmodule
`default_nettype wire

// ### flc_fault_lamp_controller_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Port checks
module flc_checker (
    input wire logic        core_clk, rst_n, engine_running, clear_codes, read_req,
    input wire logic        read_valid, read_stored, fault_lamp_reg, fault_pending_reg,
    input wire logic [15:0] fault_active, trouble_code_reg,
    input wire logic [3:0]  misfire_cyl, read_index, fuel_cutoff_reg
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_store; fault_active != 16'h0 && !clear_codes |=>
        (trouble_code_reg & $past(fault_active)) == $past(fault_active); endproperty
    a_store: assert property (p_store) else $error("fault not stored");
    property p_keep; !clear_codes |=>
        (trouble_code_reg & $past(trouble_code_reg)) == $past(trouble_code_reg); endproperty
    a_keep: assert property (p_keep) else $error("code lost");
    property p_clr; clear_codes && !fault_active && !fault_pending_reg && engine_running
        && !fuel_cutoff_reg |-> ##[1:2] !fault_lamp_reg; endproperty
    a_clr: assert property (p_clr) else $error("lamp on after clear");
    property p_cut; 1 |=> fuel_cutoff_reg == $past(misfire_cyl); endproperty
    a_cut: assert property (p_cut) else $error("cutoff wrong");
    property p_pend; 1 |=> fault_pending_reg == |$past(fault_active); endproperty
    a_pend: assert property (p_pend) else $error("pending wrong");
    property p_rv; read_req |=> read_valid; endproperty
    a_rv: assert property (p_rv) else $error("no read answer");
    property p_nv; !read_req |=> !read_valid; endproperty
    a_nv: assert property (p_nv) else $error("stray read answer");
    property p_rd; read_req |=> read_stored == 1'($past(trouble_code_reg) >> $past(read_index));
    endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");
    cover property (read_valid);
    cover property ($rose(fault_lamp_reg));
    cover property (fuel_cutoff_reg != 4'h0);
endmodule
bind flc_fault_lamp_controller flc_checker u_chk (.*);
`default_nettype wire

// ### flc_fault_lamp_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
    $display("MISMATCH %0t %h %h", $time, a, b); end end
module flc_fault_lamp_controller_bench;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        engine_running = 1'b0;
    logic        clear_codes = 1'b0;
    logic [15:0] fault_active = 16'h0;
    logic [3:0]  misfire_cyl = 4'h0;
    wire logic   read_req, read_valid, read_stored, fault_lamp_reg, fault_pending_reg;
    wire logic [3:0]  read_index, fuel_cutoff_reg;
    wire logic [15:0] trouble_code_reg;
    int          fails = 0, n_tests = 0, exp_codes = 0, k;
    logic        got;
    initial forever #12.5 core_clk = ~core_clk;
    flc_fault_lamp_controller u_dut (.*, .qual_count(24'h5), .hold_count(24'ha));
    flc_scan_tool u_tool (.*);
    task automatic go(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic set_fault(input logic [15:0] v);
        @(posedge core_clk) fault_active <= v;
        exp_codes |= v;
    endtask
    task automatic tally_and_finish;
        $display("tests %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(86));
        go(12);
        @(posedge core_clk) rst_n <= 1'b1;
        go(2);
        `CHK(fault_lamp_reg, 1'b1)
        @(posedge core_clk) engine_running <= 1'b1;
        go(4);
        `CHK(fault_lamp_reg, 1'b0)
        $display("start done");
        k = $urandom_range(15);
        set_fault(16'h1 << k);
        go(2);
        `CHK(fault_lamp_reg, 1'b0)
        `CHK(fault_pending_reg, 1'b1)
        go(10);
        `CHK(fault_lamp_reg, 1'b1)
        `CHK(trouble_code_reg, exp_codes[15:0])
        set_fault(16'h0);
        go(4);
        `CHK(fault_lamp_reg, 1'b1)
        go(14);
        `CHK(fault_lamp_reg, 1'b0)
        for (int i = 0; i < 16; i++) begin
            u_tool.fetch(4'(i), got);
            `CHK(got, exp_codes[i])
        end
        $display("hold done");
        set_fault(16'($urandom()) | 16'h8000);
        go(12);
        set_fault(16'h0);
        go(3);
        @(posedge core_clk) clear_codes <= 1'b1;
        exp_codes = 0;
        @(posedge core_clk) clear_codes <= 1'b0;
        go(2);
        `CHK(fault_lamp_reg, 1'b0)
        `CHK(trouble_code_reg, exp_codes[15:0])
        $display("clear done");
        k = $urandom_range(15, 1);
        @(posedge core_clk) misfire_cyl <= 4'(k);
        go(3);
        `CHK(fuel_cutoff_reg, 4'(k))
        `CHK(fault_lamp_reg, 1'b1)
        @(posedge core_clk) misfire_cyl <= 4'h0;
        go(3);
        `CHK(fuel_cutoff_reg, 4'h0)
        `CHK(fault_lamp_reg, 1'b0)
        $display("misfire done");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ### flc_scan_tool.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Scan tool model
module flc_scan_tool (
    input  wire logic       core_clk,
    input  wire logic       read_valid,
    input  wire logic       read_stored,
    output var  logic       read_req,
    output var  logic [3:0] read_index
);
    // Idle request until the first fetch
    initial begin
        read_req   = 1'b0;
        read_index = 4'h0;
    end
    task automatic fetch(input logic [3:0] idx, output logic bit_out);
        @(posedge core_clk) read_req <= 1'b1;
        read_index <= idx;
        @(posedge core_clk) read_req <= 1'b0;
        // Inverse index so a late sample cannot pass
        read_index <= ~idx;
        @(negedge core_clk);
        bit_out = (read_valid === 1'b1) ? read_stored : 1'bx;
    endtask
endmodule
`default_nettype wire
